/* pkg/adc_cfg_pkg.sv */
// Shared constants for the converter serial configuration port and its host
package adc_cfg_pkg;
  // ----------------------------------------
  // Device register map
  // ----------------------------------------
  localparam logic [12:0] ADDR_PORT_CFG    = 13'h0_000;
  localparam logic [12:0] ADDR_CHIP_ID     = 13'h0_001;
  localparam logic [12:0] ADDR_CHIP_GRADE  = 13'h0_002;
  localparam logic [12:0] ADDR_SHADOW_LO   = 13'h0_008;
  localparam logic [12:0] ADDR_SHADOW_HI   = 13'h0_018;
  localparam logic [12:0] ADDR_POWER_MODE  = 13'h0_008;
  localparam logic [12:0] ADDR_TEST_CTRL   = 13'h0_00D;
  localparam logic [12:0] ADDR_OUT_MODE    = 13'h0_014;
  localparam logic [12:0] ADDR_RANGE_PIN   = 13'h0_02A;
  localparam logic [12:0] ADDR_COMMIT      = 13'h0_0FF;
  localparam logic [12:0] ADDR_CUSTOMER    = 13'h0_101;
  localparam int          SHADOW_COUNT     = 17;
  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int          CFG_LSB_HI       = 6;
  localparam int          CFG_RST_HI       = 5;
  localparam int          CFG_RST_LO       = 2;
  localparam int          CFG_LSB_LO       = 1;
  localparam logic [7:0]  CFG_FIXED        = 8'h18;
  localparam logic [7:0]  RANGE_PIN_RESET  = 8'h01;
  localparam logic [7:0]  SHADOW_RESET     = 8'h00;
  localparam int          COMMIT_BIT       = 0;
  localparam int          PN_LONG_RST_BIT  = 5;
  localparam int          PN_SHORT_RST_BIT = 4;
  localparam int          TWOS_BIT         = 0;
  // ----------------------------------------
  // Instruction layout and frame lengths
  // ----------------------------------------
  localparam int          INSTR_BITS       = 16;
  localparam int          INSTR_RD_BIT     = 15;
  localparam int          LEN_HI_BIT       = 14;
  localparam int          LEN_LO_BIT       = 13;
  localparam logic [1:0]  LEN_STREAM       = 2'h3;
  // ----------------------------------------
  // Test patterns (offset binary)
  // ----------------------------------------
  localparam logic [3:0]  TP_OFF           = 4'h0;
  localparam logic [3:0]  TP_MID           = 4'h1;
  localparam logic [3:0]  TP_POS_FS        = 4'h2;
  localparam logic [3:0]  TP_NEG_FS        = 4'h3;
  localparam logic [3:0]  TP_CHECKER       = 4'h4;
  localparam logic [3:0]  TP_PN_LONG       = 4'h5;
  localparam logic [3:0]  TP_PN_SHORT      = 4'h6;
  localparam logic [3:0]  TP_TOGGLE        = 4'h7;
  localparam logic [15:0] PAT_MID          = 16'h8000;
  localparam logic [15:0] PAT_ONES         = 16'hFFFF;
  localparam logic [15:0] PAT_ZEROS        = 16'h0000;
  localparam logic [15:0] PAT_CHECK_A      = 16'hAAAA;
  localparam logic [15:0] PAT_CHECK_B      = 16'h5555;
  localparam logic [8:0]  PN_SHORT_SEED    = 9'h1FF;
  localparam logic [22:0] PN_LONG_SEED     = 23'h7F_FFFF;
  // ----------------------------------------
  // Host register map and timing
  // ----------------------------------------
  localparam logic [7:0]  HOST_CMD         = 8'h00;
  localparam logic [7:0]  HOST_WDATA       = 8'h04;
  localparam logic [7:0]  HOST_RDATA       = 8'h08;
  localparam logic [7:0]  HOST_STATUS      = 8'h0C;
  localparam logic [7:0]  HOST_CTRL        = 8'h10;
  localparam int          CMD_START_BIT    = 31;
  localparam int          CLK_PERIOD_NS    = 100;
  localparam int          SCLK_PERIOD_NS   = 1600;
  localparam int          SCLK_HALF_CYC    = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
endpackage

/* pkg/cfg_link_if.sv */
// Three-wire serial link between host and converter port
interface cfg_link_if;
  logic select_n;
  logic sclk;
  logic host_sd;
  logic host_oe;
  logic dev_sd;
  logic dev_oe;
  logic sdio;

  // Shared data line with a weak pull-up when nobody drives
  assign sdio = host_oe ? host_sd : (dev_oe ? dev_sd : 1'b1);

  modport device (input select_n, input sclk, input sdio, output dev_sd, output dev_oe);
  modport host (output select_n, output sclk, output host_sd, output host_oe, input sdio);
endinterface

/* logic/cfg_port_device.sv */
// Converter serial configuration port, register bank and test pattern path
// Summary of operation
// - Test mode replaces conversion data with pattern
// - Bits 4 or 5 reset PN generators
// - Patterns ignore input, need sample clock
// - Three wires; transfers only while select low
// - Frame starts at first rise after select
// - Select held low keeps streaming transfers
// - Select high between bytes stalls a counted frame; a streaming frame ends
// - Select never low: port released, straps active
// - Sixteen-bit instruction; length bits give bytes
// - Byte data; first bit marks read/write, last bit when LSB first
// - Data line turns around for read data
// - MSB first after reset, LSB selectable
// - Unused port: host holds select high
// - Straps: data pin powerdown, clock pin format
// - Software writes zeros to open bits
// - Reset loads register defaults
// - Shadowed registers apply on commit write
// - Commit bit clears itself
// - Config, commit, program and customer registers
// - Range pin select resets to 0x01
// - Host keeps port idle during conversion
// - Port config bits mirrored in both nibbles
module cfg_port_device #(
  parameter logic [7:0] CHIP_ID    = 8'h5A, // Arbitrary identity value
  parameter logic [7:0] CHIP_GRADE = 8'h00
) (
  input  wire logic        clk,
  input  wire logic        rst,
  cfg_link_if.device       link,
  input  wire logic [15:0] conv_data,
  input  wire logic        conv_valid,
  output logic      [15:0] out_data,
  output logic             out_valid,
  output logic             test_active,
  output logic             powerdown_control,
  output logic             format_select,
  output logic             secondary_active,
  output logic      [7:0]  range_pin_select
);
  import adc_cfg_pkg::*;

  typedef enum logic [1:0] {F_IDLE, F_INSTR, F_DATA} frame_t;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [2:0] sclk_sy;
  logic [1:0] sel_sy;
  logic [1:0] sd_sy;

  always_ff @(posedge clk) begin
    sclk_sy <= {sclk_sy[1:0], link.sclk};
    sel_sy  <= {sel_sy[0], link.select_n};
    sd_sy   <= {sd_sy[0], link.sdio};
  end

  wire sclk_rise = sclk_sy[1] & ~sclk_sy[2];
  wire sclk_fall = ~sclk_sy[1] & sclk_sy[2];
  wire sel_low   = ~sel_sy[1];
  wire sd_in     = sd_sy[1];

  // ----------------------------------------
  // Frame state
  // ----------------------------------------
  frame_t      phase;
  logic [3:0]  bit_cnt;
  logic [15:0] ishift;
  logic [7:0]  bshift;
  logic [7:0]  tx;
  logic        rd;
  logic [1:0]  len;
  logic [1:0]  left;
  logic [12:0] addr;
  logic        lsb_first;
  logic        spi_used;

  wire [15:0] next_ishift = lsb_first ? {sd_in, ishift[15:1]} : {ishift[14:0], sd_in};
  wire [7:0]  next_bshift = lsb_first ? {sd_in, bshift[7:1]} : {bshift[6:0], sd_in};
  wire        instr_done  = sclk_rise & sel_low & (phase == F_INSTR) & (bit_cnt == 4'hF);
  wire        byte_done   = sclk_rise & sel_low & (phase == F_DATA) & (bit_cnt == 4'h7);
  wire        wr_en       = byte_done & ~rd;
  wire [12:0] step_addr   = lsb_first ? addr + 13'h0_001 : addr - 13'h0_001;
  wire        last_byte   = (len != LEN_STREAM) & (left == 2'h0);

  always_ff @(posedge clk) begin
    if (rst) begin
      phase   <= F_IDLE;
      bit_cnt <= 4'h0;
      ishift  <= 16'h0000;
      bshift  <= 8'h00;
      rd      <= 1'b0;
      len     <= 2'h0;
      left    <= 2'h0;
      addr    <= 13'h0_000;
    end else if (!sel_low) begin
      // Byte-boundary stall of a counted frame is kept; anything else ends it
      if (!(phase == F_DATA && bit_cnt == 4'h0 && len != LEN_STREAM)) begin
        phase <= F_IDLE;
      end
    end else if (sclk_rise) begin
      case (phase)
        F_IDLE: begin
          phase   <= F_INSTR;
          ishift  <= next_ishift;
          bit_cnt <= 4'h1;
        end
        F_INSTR: begin
          ishift  <= next_ishift;
          bit_cnt <= bit_cnt + 4'h1;
          if (instr_done) begin
            phase   <= F_DATA;
            bit_cnt <= 4'h0;
            rd      <= next_ishift[INSTR_RD_BIT];
            len     <= next_ishift[LEN_HI_BIT:LEN_LO_BIT];
            left    <= next_ishift[LEN_HI_BIT:LEN_LO_BIT];
            addr    <= next_ishift[12:0];
          end
        end
        F_DATA: begin
          bshift  <= next_bshift;
          bit_cnt <= bit_cnt + 4'h1;
          if (byte_done) begin
            bit_cnt <= 4'h0;
            addr    <= step_addr;
            left    <= left - 2'h1;
            if (last_byte) begin
              phase <= F_IDLE;
            end
          end
        end
        default: phase <= F_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Register bank
  // ----------------------------------------
  logic [7:0] shadow [SHADOW_COUNT];
  logic [7:0] active [SHADOW_COUNT];
  logic [7:0] customer;

  wire [7:0]  wr_data   = next_bshift;
  wire        soft_rst  = wr_en & (addr == ADDR_PORT_CFG) & (wr_data[CFG_RST_HI] | wr_data[CFG_RST_LO]);
  wire        in_shadow = (addr >= ADDR_SHADOW_LO) & (addr <= ADDR_SHADOW_HI);
  wire [4:0]  sidx      = 5'(addr - ADDR_SHADOW_LO);
  wire        commit    = wr_en & (addr == ADDR_COMMIT) & wr_data[COMMIT_BIT];

  function automatic logic [7:0] act_reg(input logic [12:0] a);
    act_reg = active[5'(a - ADDR_SHADOW_LO)];
  endfunction

  always_ff @(posedge clk) begin
    if (rst || soft_rst) begin
      lsb_first        <= 1'b0;
      range_pin_select <= RANGE_PIN_RESET;
      customer         <= 8'h00;
      for (int i = 0; i < SHADOW_COUNT; i++) begin
        shadow[i] <= SHADOW_RESET;
        active[i] <= SHADOW_RESET;
      end
    end else begin
      if (wr_en && addr == ADDR_PORT_CFG) begin
        lsb_first <= wr_data[CFG_LSB_HI] | wr_data[CFG_LSB_LO];
      end
      if (wr_en && addr == ADDR_RANGE_PIN) begin
        range_pin_select <= wr_data;
      end
      if (wr_en && addr == ADDR_CUSTOMER) begin
        customer <= wr_data;
      end
      if (wr_en && in_shadow) begin
        shadow[sidx] <= wr_data;
      end
      if (commit) begin
        for (int i = 0; i < SHADOW_COUNT; i++) begin
          active[i] <= shadow[i];
        end
      end
    end
  end

  // Readback; commit register always reads zero once applied
  wire [7:0] cfg_rd = CFG_FIXED | {1'b0, lsb_first, 4'h0, lsb_first, 1'b0};
  wire [7:0] rd_byte = (addr == ADDR_PORT_CFG)   ? cfg_rd :
                       (addr == ADDR_CHIP_ID)    ? CHIP_ID :
                       (addr == ADDR_CHIP_GRADE) ? CHIP_GRADE :
                       in_shadow                 ? shadow[sidx] :
                       (addr == ADDR_RANGE_PIN)  ? range_pin_select :
                       (addr == ADDR_CUSTOMER)   ? customer : 8'h00;

  // ----------------------------------------
  // Read data driver
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      tx <= 8'h00;
    end else if (sclk_fall && sel_low && phase == F_DATA && rd) begin
      tx <= (bit_cnt == 4'h0) ? rd_byte : (lsb_first ? {1'b0, tx[7:1]} : {tx[6:0], 1'b0});
    end
  end

  assign link.dev_oe = sel_low & spi_used & (phase == F_DATA) & rd;
  assign link.dev_sd = lsb_first ? tx[0] : tx[7];

  // ----------------------------------------
  // Pin mode and straps
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      spi_used          <= 1'b0;
      powerdown_control <= 1'b0;
      format_select     <= 1'b0;
    end else begin
      if (sel_low) begin
        spi_used <= 1'b1;
      end
      if (!spi_used) begin
        powerdown_control <= sd_in;
        format_select     <= sclk_sy[1];
      end else begin
        powerdown_control <= |(act_reg(ADDR_POWER_MODE) & 8'h03);
        format_select     <= |(act_reg(ADDR_OUT_MODE) & (8'h01 << TWOS_BIT));
      end
    end
  end

  assign secondary_active = ~spi_used;

  // ----------------------------------------
  // Test pattern path
  // ----------------------------------------
  logic [8:0]  pn_short;
  logic [22:0] pn_long;
  logic        flip;

  wire [7:0]  test_reg = act_reg(ADDR_TEST_CTRL);
  wire [3:0]  tmode    = test_reg[3:0];
  wire [15:0] pattern  = (tmode == TP_MID)      ? PAT_MID :
                         (tmode == TP_POS_FS)   ? PAT_ONES :
                         (tmode == TP_NEG_FS)   ? PAT_ZEROS :
                         (tmode == TP_CHECKER)  ? (flip ? PAT_CHECK_B : PAT_CHECK_A) :
                         (tmode == TP_PN_LONG)  ? pn_long[15:0] :
                         (tmode == TP_PN_SHORT) ? {pn_short, pn_short[6:0]} :
                         (tmode == TP_TOGGLE)   ? (flip ? PAT_ZEROS : PAT_ONES) : PAT_ZEROS;
  wire [15:0] selected = (tmode == TP_OFF) ? conv_data : pattern;
  wire [15:0] formatted = format_select ? {~selected[15], selected[14:0]} : selected;

  assign test_active = (tmode != TP_OFF);

  always_ff @(posedge clk) begin
    if (rst) begin
      pn_short  <= PN_SHORT_SEED;
      pn_long   <= PN_LONG_SEED;
      flip      <= 1'b0;
      out_data  <= PAT_ZEROS;
      out_valid <= 1'b0;
    end else begin
      out_valid <= conv_valid;
      if (conv_valid) begin
        out_data <= formatted;
        flip     <= ~flip;
        pn_short <= {pn_short[7:0], pn_short[8] ^ pn_short[4]};
        pn_long  <= {pn_long[21:0], pn_long[22] ^ pn_long[17]};
      end
      if (test_reg[PN_SHORT_RST_BIT]) begin
        pn_short <= PN_SHORT_SEED;
      end
      if (test_reg[PN_LONG_RST_BIT]) begin
        pn_long <= PN_LONG_SEED;
      end
    end
  end
endmodule

/* logic/cfg_port_host.sv */
// Serial master for the converter port, commanded over AHB-Lite
module cfg_port_host #(
  parameter int HALF = adc_cfg_pkg::SCLK_HALF_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic        hwrite,
  input  wire logic [1:0]  htrans,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic      [31:0] hrdata,
  output logic             hresp,
  cfg_link_if.host         link
);
  import adc_cfg_pkg::*;

  if (HALF < 8 || HALF > 255) begin : g_half_check
    $error("HALF must lie in 8..255 for read turnaround");
  end

  typedef enum logic [1:0] {H_IDLE, H_LOW, H_HIGH, H_END} host_state_t;

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  logic        wr_pend;
  logic [7:0]  wr_addr;
  logic [15:0] cmd;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        lsb_first;
  logic        busy;

  wire       take   = hsel & htrans[1] & hready;
  wire       start  = wr_pend & (wr_addr == HOST_CMD) & hwdata[CMD_START_BIT] & ~busy;
  wire [7:0] a_addr = {haddr[7:2], 2'b00};
  wire [31:0] rd_mux = (a_addr == HOST_CMD)    ? {16'h0000, cmd} :
                       (a_addr == HOST_WDATA)  ? wdata :
                       (a_addr == HOST_RDATA)  ? rdata :
                       (a_addr == HOST_STATUS) ? {31'h0000_0000, busy} :
                       (a_addr == HOST_CTRL)   ? {31'h0000_0000, lsb_first} : 32'h0000_0000;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_pend   <= 1'b0;
      wr_addr   <= 8'h00;
      hrdata    <= 32'h0000_0000;
      cmd       <= 16'h0000;
      wdata     <= 32'h0000_0000;
      lsb_first <= 1'b0;
    end else begin
      wr_pend <= take & hwrite;
      wr_addr <= a_addr;
      if (take && !hwrite) begin
        hrdata <= rd_mux;
      end
      if (wr_pend && !busy && wr_addr == HOST_CMD) begin
        cmd <= hwdata[15:0];
      end
      if (wr_pend && !busy && wr_addr == HOST_WDATA) begin
        wdata <= hwdata;
      end
      if (wr_pend && !busy && wr_addr == HOST_CTRL) begin
        lsb_first <= hwdata[0];
      end
    end
  end

  // ----------------------------------------
  // Serial engine
  // ----------------------------------------
  host_state_t state;
  logic [7:0]  div;
  logic [5:0]  idx;
  logic [1:0]  sd_sy;

  wire       is_rd   = cmd[INSTR_RD_BIT];
  wire [5:0] last    = 6'(INSTR_BITS - 1) + {1'b0, cmd[LEN_HI_BIT:LEN_LO_BIT], 3'b111} + 6'h01;
  wire       in_data = (idx >= 6'(INSTR_BITS));
  wire [5:0] doff    = idx - 6'(INSTR_BITS);
  wire [4:0] dpos    = {doff[4:3], lsb_first ? doff[2:0] : 3'h7 - doff[2:0]};
  wire [3:0] ipos    = lsb_first ? idx[3:0] : 4'hF - idx[3:0];
  wire       tx_bit  = in_data ? wdata[dpos] : cmd[ipos];
  wire       div_end = (div == 8'(HALF - 1));

  always_ff @(posedge clk) begin
    sd_sy <= {sd_sy[0], link.sdio};
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state        <= H_IDLE;
      div          <= 8'h00;
      idx          <= 6'h00;
      busy         <= 1'b0;
      rdata        <= 32'h0000_0000;
      link.select_n <= 1'b1;
      link.sclk    <= 1'b0;
      link.host_sd <= 1'b0;
      link.host_oe <= 1'b0;
    end else begin
      div <= div_end ? 8'h00 : div + 8'h01;
      case (state)
        H_IDLE: begin
          link.select_n <= 1'b1;
          link.host_oe  <= 1'b0;
          if (start) begin
            busy          <= 1'b1;
            state         <= H_LOW;
            idx           <= 6'h00;
            div           <= 8'h00;
            link.select_n <= 1'b0;
          end
        end
        H_LOW: begin
          link.host_sd <= tx_bit;
          link.host_oe <= ~(is_rd & in_data);
          if (div_end) begin
            link.sclk <= 1'b1;
            state     <= H_HIGH;
            if (is_rd && in_data) begin
              rdata[dpos] <= sd_sy[1];
            end
          end
        end
        H_HIGH: begin
          // Free the line once the last instruction bit is sampled
          if (is_rd && idx == 6'(INSTR_BITS - 1)) begin
            link.host_oe <= 1'b0;
          end
          if (div_end) begin
            link.sclk <= 1'b0;
            idx       <= idx + 6'h01;
            state     <= (idx == last) ? H_END : H_LOW;
          end
        end
        H_END: begin
          link.host_oe <= 1'b0;
          if (div_end) begin
            link.select_n <= 1'b1;
            busy          <= 1'b0;
            state         <= H_IDLE;
          end
        end
        default: state <= H_IDLE;
      endcase
    end
  end
endmodule

/* verification/cfg_link_assertions.sv */
// Protocol checks on the serial link between host and converter port
module cfg_link_assertions (
  input wire logic clk,
  input wire logic rst,
  input wire logic select_n,
  input wire logic sclk,
  input wire logic host_sd,
  input wire logic host_oe,
  input wire logic dev_sd,
  input wire logic dev_oe,
  input wire logic sdio
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // Frame steps
  // ----------------------------------------
  sequence s_first_rise;
    !sclk ##[1:40] $rose(sclk);
  endsequence
  sequence s_bit_high;
    sclk[*8];
  endsequence
  // ----------------------------------------
  // Link rules
  // ----------------------------------------
  a_one_driver: assert property (!(host_oe && dev_oe))
    else $error("both ends drive the data line");
  a_frame_start: assert property ($fell(select_n) |-> s_first_rise)
    else $error("no clock rise after select fell");
  a_clock_gated: assert property ($rose(sclk) |-> !select_n)
    else $error("clock rise with select high");
  a_bit_width: assert property ($rose(sclk) |-> s_bit_high)
    else $error("clock high phase too short");
  a_turn_on_rise: assert property ($rose(dev_oe) |-> sclk && !select_n && !host_oe)
    else $error("device drove line outside read turnaround");
  a_release_end: assert property ($rose(select_n) |-> ##[0:4] !dev_oe)
    else $error("device kept driving after select rose");
  a_idle_quiet: assert property (select_n[*5] |-> !dev_oe)
    else $error("device drives while deselected");
  a_dev_steady: assert property (dev_oe && $past(dev_oe) && $changed(dev_sd) |-> !sclk)
    else $error("read data changed while clock high");
  a_host_steady: assert property ($rose(sclk) && host_oe |-> $stable(host_sd))
    else $error("host data changed at clock rise");
endmodule

/* verification/adc_serial_config_port_bench.sv */
// Bench joining host and converter port over the three-wire link
module adc_serial_config_port_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import adc_cfg_pkg::*;
  localparam logic [7:0] ID_ARB = 8'h3C;  // Arbitrary identity value
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [15:0] conv_data = 16'h0000;
  logic        conv_valid = 1'b0;
  logic [15:0] out_data;
  logic        out_valid;
  logic        test_active;
  logic        powerdown_control;
  logic        format_select;
  logic        secondary_active;
  logic [7:0]  range_pin_select;
  logic        chk_rd = 1'b0;
  logic [31:0] rd_q[$];
  logic [31:0] mk_q[$];
  logic [15:0] out_q[$];
  logic [31:0] r;
  logic [7:0]  bit_val;
  logic [3:0]  modes [3] = '{TP_MID, TP_POS_FS, TP_NEG_FS};
  logic [15:0] pats [3] = '{PAT_MID, PAT_ONES, PAT_ZEROS};
  int          err_total = 0;
  int          samples_checked = 0;
  int          cyc = 0;

  always #50 clk = ~clk;

  cfg_link_if cfg_link_if_i ();
  cfg_port_host cfg_port_host_i (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .hwrite(hwrite),
    .htrans(htrans), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .link(cfg_link_if_i));
  cfg_port_device #(.CHIP_ID(ID_ARB)) cfg_port_device_i (.clk(clk), .rst(rst), .link(cfg_link_if_i),
    .conv_data(conv_data), .conv_valid(conv_valid), .out_data(out_data), .out_valid(out_valid),
    .test_active(test_active), .powerdown_control(powerdown_control), .format_select(format_select),
    .secondary_active(secondary_active), .range_pin_select(range_pin_select));
  cfg_link_assertions cfg_link_assertions_i (.clk(clk), .rst(rst), .select_n(cfg_link_if_i.select_n),
    .sclk(cfg_link_if_i.sclk), .host_sd(cfg_link_if_i.host_sd), .host_oe(cfg_link_if_i.host_oe),
    .dev_sd(cfg_link_if_i.dev_sd), .dev_oe(cfg_link_if_i.dev_oe), .sdio(cfg_link_if_i.sdio));

  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task report_and_stop;
    $display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (chk_rd === 1'b1 && hreadyout === 1'b1) chk(hrdata & mk_q.pop_front(), rd_q.pop_front());
    if (out_valid === 1'b1) chk({16'h0000, out_data}, {16'h0000, out_q.pop_front()});
    if (cyc == 60000) begin
      err_total++;
      $display("ERROR %0t: timeout", $time);
      report_and_stop();
    end
  end

  // ----------------------------------------
  // Bus and link tasks
  // ----------------------------------------
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic cmp, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    chk_rd <= cmp;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
    chk_rd <= 1'b0;
  endtask

  task rd_chk(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m);
    rd_q.push_back(e);
    mk_q.push_back(m);
    ahb(1'b0, a, 32'h0000_0000, 1'b1, r);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, {24'h00_0000, a}, d, 1'b0, r);
  endtask

  task frame(input logic rw, input logic [1:0] len, input logic [12:0] a, input logic [31:0] d);
    wr(HOST_WDATA, d);
    wr(HOST_CMD, {1'b1, 15'h0000, rw, len, a});
    repeat (2) @(posedge clk);
    r = 32'h0000_0001;
    while (r[0] !== 1'b0) ahb(1'b0, {24'h00_0000, HOST_STATUS}, 32'h0000_0000, 1'b0, r);
  endtask

  task spi_wr(input logic [12:0] a, input logic [7:0] d);
    frame(1'b0, 2'h0, a, {24'h00_0000, d});
  endtask

  task spi_rd(input logic [12:0] a, input logic [1:0] len, input logic [31:0] e, input logic [31:0] m);
    frame(1'b1, len, a, 32'h0000_0000);
    rd_chk({24'h00_0000, HOST_RDATA}, e, m);
  endtask

  task sample(input logic [15:0] pat, input logic pass);
    logic [15:0] v;
    v = 16'($urandom);
    out_q.push_back(pass ? v : pat);
    conv_data <= v;
    conv_valid <= 1'b1;
    @(posedge clk);
    conv_valid <= 1'b0;
    @(posedge clk);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    void'($urandom(21));
    repeat (3) @(posedge clk);
    chk({31'h0, secondary_active}, 32'h0000_0001);
    chk({31'h0, powerdown_control}, 32'h0000_0001);
    chk({31'h0, format_select}, 32'h0000_0000);
    chk({24'h0, range_pin_select}, 32'h0000_0001);
    spi_rd(ADDR_PORT_CFG, 2'h0, {24'h0, CFG_FIXED}, 32'h0000_00FF);
    chk({31'h0, secondary_active}, 32'h0000_0000);
    chk({31'h0, powerdown_control}, 32'h0000_0000);
    spi_rd(ADDR_CHIP_GRADE, 2'h2, {8'h00, CFG_FIXED, ID_ARB, 8'h00}, 32'h00FF_FFFF);
    spi_rd(13'h0_003, LEN_STREAM, {CFG_FIXED, ID_ARB, 16'h0000}, 32'hFFFF_FFFF);
    bit_val = 8'($urandom) & 8'h01;
    spi_wr(ADDR_RANGE_PIN, bit_val);
    chk({24'h0, range_pin_select}, {24'h0, bit_val});
    spi_rd(ADDR_RANGE_PIN, 2'h0, {24'h0, bit_val}, 32'h0000_00FF);
    spi_wr(ADDR_TEST_CTRL, {4'h0, TP_MID});
    chk({31'h0, test_active}, 32'h0000_0000);
    sample(16'h0000, 1'b1);
    spi_wr(ADDR_COMMIT, 8'h01);
    chk({31'h0, test_active}, 32'h0000_0001);
    spi_rd(ADDR_COMMIT, 2'h0, 32'h0000_0000, 32'h0000_00FF);
    for (int i = 0; i < 3; i++) begin
      spi_wr(ADDR_TEST_CTRL, {4'h0, modes[i]});
      spi_wr(ADDR_COMMIT, 8'h01);
      sample(pats[i], 1'b0);
    end
    spi_wr(ADDR_TEST_CTRL, {4'h0, TP_OFF});
    spi_wr(ADDR_COMMIT, 8'h01);
    chk({31'h0, test_active}, 32'h0000_0000);
    sample(16'h0000, 1'b1);
    spi_wr(ADDR_PORT_CFG, 8'h5A);
    wr(HOST_CTRL, 32'h0000_0001);
    spi_rd(ADDR_PORT_CFG, 2'h0, 32'h0000_005A, 32'h0000_00FF);
    spi_wr(ADDR_PORT_CFG, CFG_FIXED);
    wr(HOST_CTRL, 32'h0000_0000);
    spi_rd(ADDR_PORT_CFG, 2'h0, {24'h0, CFG_FIXED}, 32'h0000_00FF);
    rd_chk(32'h0000_0020, 32'h0000_0000, 32'hFFFF_FFFF);
    repeat (4) @(posedge clk);
    report_and_stop();
  end
endmodule
